// ==== src/hsft_defs.vh ====
// constants for the hot-swap fault timer block
`ifndef HSFT_DEFS_VH
`define HSFT_DEFS_VH
// clock and time base
`define HSFT_CLK_NS 8
`define HSFT_TICK_US 10
`define HSFT_NS_PER_US 1000
`define HSFT_STEP_NS 25
`define HSFT_STRONG_PD_NS 15000
`define HSFT_FAULT_HOLD_NS 20000
`define HSFT_DISCH_US 10000
// apb register byte addresses
`define HSFT_A_CTRL 8'h00
`define HSFT_A_CFG0 8'h04
`define HSFT_A_CFG1 8'h08
`define HSFT_A_STATUS 8'h0c
`define HSFT_A_IRQ_STAT 8'h10
`define HSFT_A_IRQ_MASK 8'h14
`define HSFT_A_WDOG_KICK 8'h18
// ctrl fields
`define HSFT_CTRL_EN 0
`define HSFT_CTRL_FASTPD 1
`define HSFT_CTRL_RETRY 2
`define HSFT_CTRL_WDOG 3
// cfg0 field low bits, 3 bits each except watchdog
`define HSFT_F_UV 0
`define HSFT_F_OV 3
`define HSFT_F_OVIN 6
`define HSFT_F_OUV 9
`define HSFT_F_OVOUT 12
`define HSFT_F_SOAD 15
`define HSFT_F_COOL 18
`define HSFT_F_RETRY 21
`define HSFT_F_WDOG 24
// timer indices
`define HSFT_T_UV 0
`define HSFT_T_OV 1
`define HSFT_T_OVIN 2
`define HSFT_T_OUV 3
`define HSFT_T_OVOUT 4
`define HSFT_T_SOAD 5
`define HSFT_T_WDOG 6
`define HSFT_T_COOL 7
`define HSFT_T_RETRY 8
`define HSFT_NTIM 9
// interrupt status bit of the discharge failure
`define HSFT_I_SGD 7
// sequencer states
`define HSFT_S_IDLE 3'h0
`define HSFT_S_ON 3'h1
`define HSFT_S_STEP1 3'h2
`define HSFT_S_FAULT 3'h3
`define HSFT_S_COOL 3'h4
`define HSFT_S_RETRY 3'h5
`endif

// ==== src/hsft_top.v ====
// hot-swap fault and protection timers with apb register access
// Overview of operation
// (RULE_01) discharge supervised ten ms, else discharge-fail fault
// (RULE_02) fast pull-down pulse fifteen us on fault
// (RULE_03) gate turn-off within one us of trigger
// (RULE_04) timed faults trigger only after timer expiry
// (RULE_05) fault pin held at least twenty us
// (RULE_06) cool-down doubles from one to sixty-four seconds
// (RULE_07) retry-ok delay from eight-value seconds table
// (RULE_08) first-step delay counts twenty-five ns units
// (RULE_09) undervoltage timer zero to thousand ms
// (RULE_10) overvoltage timer zero to thousand ms
// (RULE_11) input overvoltage filter zero to thousand us
// (RULE_12) output undervoltage timer zero to thousand ms
// (RULE_13) output overvoltage hold in 150 us steps
// (RULE_14) watchdog five to fifteen thousand ms
// (RULE_15) overcurrent area deglitch zero to ten ms
// (RULE_16) garbled code columns taken in ascending order
// (RULE_17) timers restart on drop; code zero immediate (the watchdog timer gives 5 ms at code zero instead)
`timescale 1ns/1ps
`include "hsft_defs.vh"

module hsft_top #(
	parameter TICK_CYC = `HSFT_TICK_US * `HSFT_NS_PER_US / `HSFT_CLK_NS,
	parameter STRONG_PD_CYC = `HSFT_STRONG_PD_NS / `HSFT_CLK_NS,
	parameter HOLD_CYC = (`HSFT_FAULT_HOLD_NS + `HSFT_CLK_NS - 1) / `HSFT_CLK_NS
) (
	input wire clock, // 125 MHz clock
	input wire srst, // synchronous reset, active high
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error on unmapped address
	input wire uv_det, // undervoltage comparator
	input wire ov_det, // overvoltage comparator
	input wire ovin_det, // input overvoltage comparator
	input wire ouv_det, // output undervoltage comparator
	input wire ovout_det, // output overvoltage comparator
	input wire oc_det, // overcurrent / safe area comparator
	input wire vgs_low, // gate-source below discharge threshold
	input wire retry_ok, // retry conditions met
	output reg gate_on, // gate drive enable
	output reg gate_step1, // first-step soft turn-off
	output reg gate_pd, // gate discharge active
	output reg gate_strong_pd, // strong pull-down switch
	output reg fault_n_o, // fault pin drive level, always low
	output reg fault_n_oe, // fault pin driven low
	output reg gate_discharge_fail_fault, // discharge failure flag
	output reg irq // level interrupt
);

	// time table in microseconds per timer and code
	function [31:0] hsft_us;
		input [3:0] idx;
		input [3:0] code;
		reg [31:0] ms;
		begin
			ms = 32'h0;
			hsft_us = 32'h0;
			case (code[2:0])
				3'h1: ms = 32'd1;
				3'h2: ms = 32'd5;
				3'h3: ms = 32'd10;
				3'h4: ms = 32'd50;
				3'h5: ms = 32'd100;
				3'h6: ms = 32'd500;
				3'h7: ms = 32'd1000;
				default: ms = 32'h0;
			endcase
			case (idx)
				`HSFT_T_UV, `HSFT_T_OV, `HSFT_T_OUV: hsft_us = ms * `HSFT_NS_PER_US; // RULE_09 RULE_10 RULE_12
				`HSFT_T_OVIN: begin
					case (code[2:0]) // RULE_11
						3'h1: hsft_us = 32'd10;
						3'h2: hsft_us = 32'd20;
						3'h3: hsft_us = 32'd50;
						3'h4: hsft_us = 32'd100;
						3'h5: hsft_us = 32'd200;
						3'h6: hsft_us = 32'd500;
						3'h7: hsft_us = 32'd1000;
						default: hsft_us = 32'h0;
					endcase
				end
				`HSFT_T_OVOUT: begin
					if (code[2:0] != 3'h0) begin
						hsft_us = 32'd100 + 32'd150 * {29'h0, code[2:0] - 3'h1}; // RULE_13
					end
				end
				`HSFT_T_SOAD: begin
					case (code[2:0]) // RULE_15 RULE_16
						3'h1: hsft_us = 32'd500;
						3'h2: hsft_us = 32'd1000;
						3'h3: hsft_us = 32'd2000;
						3'h4: hsft_us = 32'd4000;
						3'h5: hsft_us = 32'd6100;
						3'h6: hsft_us = 32'd8000;
						3'h7: hsft_us = 32'd10000;
						default: hsft_us = 32'h0;
					endcase
				end
				`HSFT_T_COOL: begin
					if (code[2:0] != 3'h0) begin
						hsft_us = 32'd1000000 << (code[2:0] - 3'h1); // RULE_06
					end
				end
				`HSFT_T_RETRY: begin
					case (code[2:0]) // RULE_07 RULE_16
						3'h1: hsft_us = 32'd500000;
						3'h2: hsft_us = 32'd1000000;
						3'h3: hsft_us = 32'd2000000;
						3'h4: hsft_us = 32'd3000000;
						3'h5: hsft_us = 32'd4000000;
						3'h6: hsft_us = 32'd6000000;
						3'h7: hsft_us = 32'd8000000;
						default: hsft_us = 32'h0;
					endcase
				end
				`HSFT_T_WDOG: begin
					case (code) // RULE_14
						4'h0: hsft_us = 32'd5000;
						4'h1: hsft_us = 32'd10000;
						4'h2: hsft_us = 32'd20000;
						4'h3: hsft_us = 32'd50000;
						4'h4: hsft_us = 32'd100000;
						4'h5: hsft_us = 32'd200000;
						4'h6: hsft_us = 32'd500000;
						4'h7: hsft_us = 32'd1000000;
						4'h8: hsft_us = 32'd2000000;
						4'h9: hsft_us = 32'd3000000;
						4'ha: hsft_us = 32'd4000000;
						4'hb: hsft_us = 32'd5000000;
						4'hc: hsft_us = 32'd7500000;
						4'hd: hsft_us = 32'd10000000;
						4'he: hsft_us = 32'd12500000;
						default: hsft_us = 32'd15000000;
					endcase
				end
				default: hsft_us = 32'h0;
			endcase
		end
	endfunction

	// registers
	reg [3:0] ctrl_r;
	reg [27:0] cfg0_r;
	reg [9:0] step_cnt_r; // first_step_powerdown_count
	reg [7:0] istat_r;
	reg [7:0] imask_r;
	reg kick_r;
	reg [2:0] state_r;
	reg [7:0] meta_r;
	reg [7:0] sync_r;
	reg [15:0] tick_cnt_r;
	reg tick_r;
	reg [14:0] step_ns_r;
	reg [23:0] disch_r;
	reg [15:0] strong_r;
	reg [15:0] hold_r;
	reg [6:0] qual_d_r;

	// input synchronisers
	always @(posedge clock) begin
		if (srst) begin
			meta_r <= 8'h00;
			sync_r <= 8'h00;
		end else begin
			meta_r <= {retry_ok, vgs_low, oc_det, ovout_det, ouv_det, ovin_det, ov_det, uv_det};
			sync_r <= meta_r;
		end
	end

	// ten microsecond tick enable
	always @(posedge clock) begin
		if (srst) begin
			tick_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (tick_cnt_r == TICK_CYC[15:0] - 16'h0001) begin
			tick_cnt_r <= 16'h0000;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// timer conditions and codes
	wire on_st = (state_r == `HSFT_S_ON);
	wire [`HSFT_NTIM-1:0] tcond = {
		(state_r == `HSFT_S_RETRY) & sync_r[7],
		(state_r == `HSFT_S_COOL),
		on_st & ctrl_r[`HSFT_CTRL_WDOG] & ~kick_r,
		sync_r[5:0]
	};
	wire [4*`HSFT_NTIM-1:0] tcode = {
		1'b0, cfg0_r[`HSFT_F_RETRY +: 3],
		1'b0, cfg0_r[`HSFT_F_COOL +: 3],
		cfg0_r[`HSFT_F_WDOG +: 4],
		1'b0, cfg0_r[`HSFT_F_SOAD +: 3],
		1'b0, cfg0_r[`HSFT_F_OVOUT +: 3],
		1'b0, cfg0_r[`HSFT_F_OUV +: 3],
		1'b0, cfg0_r[`HSFT_F_OVIN +: 3],
		1'b0, cfg0_r[`HSFT_F_OV +: 3],
		1'b0, cfg0_r[`HSFT_F_UV +: 3]
	};
	wire [`HSFT_NTIM-1:0] qual;

	// qualification timers, one per condition
	genvar g;
	generate
		for (g = 0; g < `HSFT_NTIM; g = g + 1) begin : tm
			localparam [3:0] TIDX = g;
			wire [31:0] lim_us = hsft_us(TIDX, tcode[4*g +: 4]);
			wire [31:0] lim_w = lim_us / `HSFT_TICK_US;
			wire [23:0] lim = lim_w[23:0];
			reg [23:0] cnt_r;
			reg done_r;
			always @(posedge clock) begin
				if (srst || !tcond[g]) begin
					cnt_r <= 24'h000000; // RULE_17
					done_r <= 1'b0;
				end else if (lim == 24'h000000 || cnt_r >= lim) begin
					done_r <= 1'b1; // RULE_04 RULE_17
				end else if (tick_r) begin
					cnt_r <= cnt_r + 24'h000001;
				end
			end
			assign qual[g] = done_r & tcond[g];
		end
	endgenerate

	wire fault_any = |qual[`HSFT_T_WDOG:0];
	wire en = ctrl_r[`HSFT_CTRL_EN];
	// products kept at full width, then cut to the counter widths on purpose
	wire [31:0] step_prod = {22'h000000, step_cnt_r} * `HSFT_STEP_NS;
	wire [14:0] step_lim = step_prod[14:0]; // RULE_08
	wire [31:0] disch_w = `HSFT_DISCH_US / `HSFT_TICK_US;
	wire [23:0] disch_lim = disch_w[23:0];
	wire [31:0] step_inc_w = `HSFT_CLK_NS;
	wire [14:0] step_inc = step_inc_w[14:0];
	wire disch_exp = (disch_r >= disch_lim);

	// fault sequencer: turn-off, first step, discharge, cool-down, retry
	always @(posedge clock) begin
		if (srst) begin
			state_r <= `HSFT_S_IDLE;
			step_ns_r <= 15'h0000;
			disch_r <= 24'h000000;
			gate_discharge_fail_fault <= 1'b0;
		end else begin
			case (state_r)
				`HSFT_S_IDLE: begin
					gate_discharge_fail_fault <= 1'b0;
					if (en) begin
						state_r <= `HSFT_S_ON;
					end
				end
				`HSFT_S_ON: begin
					step_ns_r <= 15'h0000;
					if (fault_any) begin
						state_r <= `HSFT_S_STEP1; // RULE_03 RULE_04
					end else if (!en) begin
						state_r <= `HSFT_S_IDLE;
					end
				end
				`HSFT_S_STEP1: begin
					disch_r <= 24'h000000;
					if (step_ns_r >= step_lim) begin
						state_r <= `HSFT_S_FAULT; // RULE_08
					end else begin
						step_ns_r <= step_ns_r + step_inc;
					end
				end
				`HSFT_S_FAULT: begin
					if (!disch_exp && tick_r) begin
						disch_r <= disch_r + 24'h000001; // RULE_01
					end
					if (disch_exp && !sync_r[6]) begin
						gate_discharge_fail_fault <= 1'b1; // RULE_01
					end
					if (!en) begin
						state_r <= `HSFT_S_IDLE;
					end else if (!fault_any && disch_exp && ctrl_r[`HSFT_CTRL_RETRY]) begin
						state_r <= `HSFT_S_COOL;
					end
				end
				`HSFT_S_COOL: begin
					if (!en) begin
						state_r <= `HSFT_S_IDLE;
					end else if (qual[`HSFT_T_COOL]) begin
						state_r <= `HSFT_S_RETRY; // RULE_06
					end
				end
				`HSFT_S_RETRY: begin
					if (!en) begin
						state_r <= `HSFT_S_IDLE;
					end else if (qual[`HSFT_T_RETRY]) begin
						state_r <= `HSFT_S_ON; // RULE_07
					end
				end
				default: state_r <= `HSFT_S_IDLE;
			endcase
		end
	end

	// gate drive, strong pulse and fault pin hold
	always @(posedge clock) begin
		if (srst) begin
			gate_on <= 1'b0;
			gate_step1 <= 1'b0;
			gate_pd <= 1'b0;
			gate_strong_pd <= 1'b0;
			strong_r <= 16'h0000;
			hold_r <= 16'h0000;
			fault_n_o <= 1'b0;
			fault_n_oe <= 1'b0;
		end else begin
			fault_n_o <= 1'b0;
			gate_on <= on_st & ~fault_any & en; // RULE_03
			gate_step1 <= (state_r == `HSFT_S_STEP1);
			gate_pd <= (state_r == `HSFT_S_FAULT) | (state_r == `HSFT_S_IDLE);
			if (on_st && fault_any && ctrl_r[`HSFT_CTRL_FASTPD]) begin
				strong_r <= STRONG_PD_CYC[15:0]; // RULE_02
				gate_strong_pd <= 1'b1;
			end else if (strong_r > 16'h0001) begin
				strong_r <= strong_r - 16'h0001;
			end else begin
				strong_r <= 16'h0000;
				gate_strong_pd <= 1'b0;
			end
			if (on_st && fault_any) begin
				fault_n_oe <= 1'b1;
				hold_r <= HOLD_CYC[15:0]; // RULE_05
			end else if (hold_r > 16'h0001) begin
				hold_r <= hold_r - 16'h0001;
			end else begin
				hold_r <= 16'h0000;
				if (!fault_any && state_r != `HSFT_S_STEP1) begin
					fault_n_oe <= 1'b0; // RULE_05
				end
			end
		end
	end

	// apb slave: one wait state, read-clear interrupt status
	wire acc = psel & penable & ~pready;
	wire wr = acc & pwrite;
	wire rd_istat = acc & ~pwrite & (paddr == `HSFT_A_IRQ_STAT);
	reg irq_sgd_d;
	wire [7:0] ev = {gate_discharge_fail_fault & ~istat_r[`HSFT_I_SGD] & ~irq_sgd_d,
		qual[`HSFT_T_WDOG:0] & ~qual_d_r};
	wire [7:0] istat_nxt = (rd_istat ? 8'h00 : istat_r) | ev;
	wire [31:0] status_w = {16'h0000, sync_r, fault_n_oe, gate_strong_pd, gate_pd,
		gate_step1, gate_on, state_r};

	always @(posedge clock) begin
		if (srst) begin
			ctrl_r <= 4'h0;
			cfg0_r <= 28'h0000000;
			step_cnt_r <= 10'h000;
			imask_r <= 8'h00;
			istat_r <= 8'h00;
			kick_r <= 1'b0;
			qual_d_r <= 7'h00;
			irq_sgd_d <= 1'b0;
			irq <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			qual_d_r <= qual[`HSFT_T_WDOG:0];
			irq_sgd_d <= gate_discharge_fail_fault;
			istat_r <= istat_nxt;
			irq <= |(istat_r & imask_r);
			kick_r <= wr & (paddr == `HSFT_A_WDOG_KICK);
			pready <= acc;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (acc) begin
				case (paddr)
					`HSFT_A_CTRL: begin
						prdata <= {28'h0000000, ctrl_r};
						if (pwrite) ctrl_r <= pwdata[3:0];
					end
					`HSFT_A_CFG0: begin
						prdata <= {4'h0, cfg0_r};
						if (pwrite) cfg0_r <= pwdata[27:0];
					end
					`HSFT_A_CFG1: begin
						prdata <= {22'h000000, step_cnt_r};
						if (pwrite) step_cnt_r <= pwdata[9:0];
					end
					`HSFT_A_STATUS: prdata <= status_w;
					`HSFT_A_IRQ_STAT: prdata <= {24'h000000, istat_r};
					`HSFT_A_IRQ_MASK: begin
						prdata <= {24'h000000, imask_r};
						if (pwrite) imask_r <= pwdata[7:0];
					end
					`HSFT_A_WDOG_KICK: prdata <= 32'h00000000;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule // hsft_top

// ==== sim/hsft_gate_model.sv ====
// gate and fault line model for the fault timer bench
`timescale 1ns/1ps
module hsft_gate_model (
	input wire clock, // clock
	input wire gate_pd, // discharge
	input wire gate_strong_pd, // strong pd
	input wire fault_n_o, // pin level
	input wire fault_n_oe, // pin drive
	input wire slow, // gate stuck high
	output logic vgs_low, // gate below threshold
	output wire fault_line // pulled-up line
);
	integer q = 0;
	initial vgs_low = 1'b0;
	// gate charge drains while discharged, faster with strong pd
	always @(posedge clock) begin
		if (!gate_pd)
			q <= 0;
		else if (!slow)
			q <= q + (gate_strong_pd ? 8 : 1);
		vgs_low <= (q >= 200);
	end
	// open drain line with pull-up
	assign fault_line = fault_n_oe ? fault_n_o : 1'b1;
endmodule // hsft_gate_model

// ==== sim/hsft_top_assertions.sv ====
// port checks for the fault timer block
`timescale 1ns/1ps
module hsft_top_assertions #(
	parameter TICK_CYC = 1250,
	parameter STRONG_PD_CYC = 1875,
	parameter HOLD_CYC = 2500
) (
	input wire clock, // clock
	input wire srst, // reset
	input wire gate_on, // gate on
	input wire gate_step1, // step one
	input wire gate_pd, // discharge
	input wire gate_strong_pd, // strong pd
	input wire fault_n_o, // pin level
	input wire fault_n_oe, // pin drive
	input wire gate_discharge_fail_fault // fail flag
);
	localparam integer DLO = 999 * TICK_CYC;
	integer oe_c, sp_c, pd_c;
	// run lengths of pin drive, strong pulse and discharge
	always @(posedge clock) begin
		oe_c <= (fault_n_oe && !srst) ? oe_c + 1 : 0;
		sp_c <= (gate_strong_pd && !srst) ? sp_c + 1 : 0;
		pd_c <= (gate_pd && !srst) ? pd_c + 1 : 0;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	a_pin_hold: assert property ($fell(fault_n_oe) |-> oe_c >= HOLD_CYC)
		else $error("fault pin released early");
	a_strong_len: assert property ($fell(gate_strong_pd) |-> sp_c >= STRONG_PD_CYC - 1
		&& sp_c <= STRONG_PD_CYC + 1) else $error("strong pulse length wrong");
	a_off_fault: assert property ($rose(fault_n_oe) |-> !gate_on [*2])
		else $error("gate on at fault");
	a_on_alone: assert property (gate_on |-> !(gate_pd || gate_strong_pd))
		else $error("gate on while pulled down");
	a_step_pin: assert property (gate_step1 |-> fault_n_oe && !gate_on)
		else $error("first step without fault");
	a_step_pd: assert property ($fell(gate_step1) |-> gate_pd)
		else $error("no discharge after first step");
	a_disch_wait: assert property ($rose(gate_discharge_fail_fault) |-> pd_c >= DLO)
		else $error("discharge fail too soon");
	a_pin_low: assert property (fault_n_oe |-> !fault_n_o)
		else $error("fault pin driven high");
endmodule // hsft_top_assertions

// ==== sim/tb_top.sv ====
// self-checking bench for the hot-swap fault timers
`timescale 1ns/1ps
`include "hsft_defs.vh"
module tb_top;
	localparam integer TK = 5;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [5:0] det = 6'h00;
	logic retry_ok = 1'b1;
	logic slow = 1'b0;
	logic er;
	logic [31:0] rd;
	logic [31:0] msk = 32'hff;
	logic [31:0] st = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, gate_on, gate_step1, gate_pd, gate_strong_pd;
	wire fault_n_o, fault_n_oe, fail, irq, vgs_low, fault_line;
	integer n_errors = 0;
	integer total_checks = 0;
	integer k;
	// free running clock
	always #4 clock = ~clock;
	hsft_top #(.TICK_CYC(TK), .STRONG_PD_CYC(20), .HOLD_CYC(40)) dut (
		.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.uv_det(det[0]), .ov_det(det[1]), .ovin_det(det[2]), .ouv_det(det[3]),
		.ovout_det(det[4]), .oc_det(det[5]), .vgs_low(vgs_low), .retry_ok(retry_ok),
		.gate_on(gate_on), .gate_step1(gate_step1), .gate_pd(gate_pd),
		.gate_strong_pd(gate_strong_pd), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
		.gate_discharge_fail_fault(fail), .irq(irq));
	hsft_gate_model u_gate (.clock(clock), .gate_pd(gate_pd), .gate_strong_pd(gate_strong_pd),
		.fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .slow(slow), .vgs_low(vgs_low),
		.fault_line(fault_line));
	// compare and count
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task cyc(input integer c);
		repeat (c) @(posedge clock);
	endtask
	// one apb transfer, read data left in rd and er
	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clock);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge clock);
				n = n + 1;
			end while (pready !== 1'b1 && n < 50);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			chk(n < 50, 1);
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d errors %0d", total_checks, n_errors);
			if (n_errors == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// register access kinds and the unmapped slot
	task regs;
		begin
			apb(0, `HSFT_A_STATUS, 0);
			chk(rd & 32'hff, 32'h20);
			apb(1, `HSFT_A_CFG0, 32'hffffffff);
			apb(0, `HSFT_A_CFG0, 0);
			chk(rd, 32'h0fffffff);
			apb(1, `HSFT_A_CFG1, 32'hffffffff);
			apb(0, `HSFT_A_CFG1, 0);
			chk(rd, 32'h3ff);
			apb(0, 8'h1c, 0);
			chk(er, 1);
			chk(rd, 0);
			apb(0, `HSFT_A_WDOG_KICK, 0);
			chk(rd, 0);
		end
	endtask
	// start the gate, raise cause m and time the turn-off against t ticks
	task trip(input [5:0] m, input [31:0] cfg, input [3:0] ctl, input integer t, g);
		integer n;
		logic [31:0] ib;
		begin
			ib = (m == 0) ? 32'h40 : {26'h0, m};
			apb(1, `HSFT_A_CTRL, 0);
			apb(1, `HSFT_A_CFG0, cfg);
			apb(1, `HSFT_A_CFG1, st);
			apb(1, `HSFT_A_IRQ_MASK, msk);
			apb(1, `HSFT_A_CTRL, {28'h0, ctl});
			n = 0;
			while (gate_on !== 1'b1 && n < 100) begin
				cyc(1);
				n = n + 1;
			end
			chk(gate_on, 1);
			// a short glitch must leave the gate on
			if (g > 0) begin
				det <= m;
				cyc(g);
				det <= 6'h00;
				cyc(4);
				chk(gate_on, 1);
			end
			det <= m;
			n = 0;
			while (gate_on === 1'b1 && n < 20000) begin
				cyc(1);
				n = n + 1;
			end
			chk(n >= t * TK - TK && n <= t * TK + 3 * TK, 1);
			chk(gate_strong_pd, ctl[1]);
			chk(fault_line, 0);
			cyc(1);
			n = 0;
			while (gate_step1 === 1'b1 && n < 5000) begin
				cyc(1);
				n = n + 1;
			end
			chk(n >= (st * 25 + 7) / 8 && n <= (st * 25 + 7) / 8 + 2, 1);
			det <= 6'h00;
			cyc(2);
			chk(irq, |(ib & msk));
			apb(0, `HSFT_A_IRQ_STAT, 0);
			chk(rd, ib);
			cyc(2);
			chk(irq, 0);
			cyc(60);
		end
	endtask
	// main sequence
	initial begin
		cyc(5);
		srst <= 1'b0;
		cyc(3);
		regs;
		trip(6'h01, 32'h2, 4'h1, 500, 0);
		trip(6'h01, 32'h1, 4'h1, 100, 300);
		trip(6'h02, 32'h1 << 3, 4'h3, 100, 0);
		trip(6'h04, 32'h3 << 6, 4'h1, 5, 0);
		trip(6'h08, 32'h1 << 9, 4'h1, 100, 0);
		trip(6'h10, 32'h2 << 12, 4'h1, 25, 0);
		trip(6'h20, 32'h5 << 15, 4'h3, 610, 0);
		trip(6'h20, 32'h1 << 15, 4'h1, 50, 0);
		trip(6'h00, 32'h0, 4'h9, 500, 0);
		st = 32'd1023;
		trip(6'h02, 0, 4'h1, 0, 0);
		st = 32'h0;
		msk = 32'h0;
		trip(6'h08, 0, 4'h1, 0, 0);
		msk = 32'h80;
		slow <= 1'b1;
		trip(6'h02, 0, 4'h1, 0, 0);
		cyc(4800);
		chk(fail, 0);
		cyc(400);
		chk(fail, 1);
		apb(0, `HSFT_A_IRQ_STAT, 0);
		chk(rd, 32'h80);
		slow <= 1'b0;
		trip(6'h02, 0, 4'h5, 0, 0);
		k = 0;
		while (gate_on !== 1'b1 && k < 8000) begin
			cyc(1);
			k = k + 1;
		end
		chk(k > 4700 && k < 5300, 1);
		give_verdict;
	end
	// hang guard
	initial begin
		#600000;
		n_errors = n_errors + 1;
		give_verdict;
	end
endmodule // tb_top
bind hsft_top hsft_top_assertions #(.TICK_CYC(TICK_CYC), .STRONG_PD_CYC(STRONG_PD_CYC),
	.HOLD_CYC(HOLD_CYC)) u_chk (.clock(clock), .srst(srst), .gate_on(gate_on),
	.gate_step1(gate_step1), .gate_pd(gate_pd), .gate_strong_pd(gate_strong_pd),
	.fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
	.gate_discharge_fail_fault(gate_discharge_fail_fault));
